//--- cvtreg_host.sv
// Serial bus host model, open drain on a pulled-up data line
`default_nettype none
module cvtreg_host (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic t(input int n);
    repeat (n) @(posedge clk);
  endtask : t
  // Data moves mid low phase; phases of 8 cycles cover the pin sync
  task automatic bitx(input logic b, output logic r);
    t(4);
    sda_low <= !b;
    t(4);
    scl <= 1'b1;
    t(8);
    r = sda;
    scl <= 1'b0;
  endtask : bitx
  task automatic byte_x(input logic [8:0] v, output logic [8:0] w);
    for (int i = 8; i >= 0; i--)
      bitx(v[i], w[i]);
  endtask : byte_x
  task automatic start;
    t(4);
    sda_low <= 1'b0;
    t(4);
    scl <= 1'b1;
    t(8);
    sda_low <= 1'b1;
    t(8);
    scl <= 1'b0;
  endtask : start
  task automatic stop;
    t(4);
    sda_low <= 1'b1;
    t(4);
    scl <= 1'b1;
    t(8);
    sda_low <= 1'b0;
    t(8);
  endtask : stop
  // Flags clear by writing one to them; a soft reset or undervoltage restart sets the reset event flag and clears every other flag not set in that cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    output logic ok);
    logic [8:0] w0, w1, w2;
    start;
    byte_x({cvtreg_pkg::DEV_ADDR, 2'b01}, w0);
    byte_x({a, 1'b1}, w1);
    byte_x({d, 1'b1}, w2);
    stop;
    ok = !(w0[0] | w1[0] | w2[0]);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    logic [8:0] w0, w1, w2, w3;
    start;
    byte_x({cvtreg_pkg::DEV_ADDR, 2'b01}, w0);
    byte_x({a, 1'b1}, w1);
    start;
    byte_x({cvtreg_pkg::DEV_ADDR, 2'b11}, w2);
    byte_x(9'h1FF, w3);
    stop;
    d = w3[8:1];
    ok = !(w0[0] | w1[0] | w2[0]);
  endtask : rd
endmodule : cvtreg_host
`default_nettype wire

//--- cvtreg_pkg.sv
// Constants shared by the converter control register slice
`default_nettype none
package cvtreg_pkg;
  // Register offsets on the serial port
  localparam logic [7:0] OFF_ENABLE_EDGE_DELAYS = 8'h12;
  localparam logic [7:0] OFF_SOFTWARE_RESET_REQUEST = 8'h16;
  localparam logic [7:0] OFF_GENERAL_CONFIGURATION = 8'h17;
  localparam logic [7:0] OFF_TOP_INTERRUPT_FLAGS = 8'h18;
  localparam logic [7:0] OFF_CONVERTER_0_1_FLAGS = 8'h19;
  localparam logic [7:0] OFF_CONVERTER_2_3_FLAGS = 8'h1A;
  localparam logic [7:0] OFF_LIVE_STATUS = 8'h1B;
  // Field positions
  localparam int OFF_DELAY_MSB = 7;
  localparam int OFF_DELAY_LSB = 4;
  localparam int ON_DELAY_MSB = 3;
  localparam int ON_DELAY_LSB = 0;
  localparam int SOFT_RESET_BIT = 0;
  localparam int WARN_SEL_BIT = 3;
  localparam int PD_TWO_BIT = 2;
  localparam int PD_ONE_BIT = 1;
  localparam int SPREAD_BIT = 0;
  localparam int TSD_BIT = 3;
  localparam int TWARN_BIT = 2;
  localparam int RESET_EVT_BIT = 1;
  localparam int LOAD_RDY_BIT = 0;
  // Writable flag masks of the per-converter registers
  localparam logic [7:0] CONV01_MASK = 8'h17;
  localparam logic [7:0] CONV23_MASK = 8'h11;
  // Values after reset
  localparam logic [7:0] RST_DELAYS = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h06;
  localparam logic [3:0] RST_TOP_FLAGS = 4'h2;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DELAY_STEP_US = 1000;
  // One step in clock cycles: microseconds times 1e6 gives picoseconds
  localparam int MS_CYCLES = (DELAY_STEP_US * 1000000) / CLK_PERIOD_PS;
  // Serial port slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  typedef enum {SEQ_OFF, SEQ_START_WAIT, SEQ_ON, SEQ_STOP_WAIT} cvtreg_seq_e;
  typedef enum {SP_IDLE, SP_ADDR, SP_ADDR_ACK, SP_PTR, SP_PTR_ACK, SP_WDATA,
    SP_WDATA_ACK, SP_RDATA, SP_RDATA_ACK} cvtreg_sp_e;
endpackage : cvtreg_pkg
`default_nettype wire

//--- cvtreg_serial.sv
// Serial port slave giving byte access to the register slice
`default_nettype none
module cvtreg_serial (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sreset,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe_n,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  input wire logic [7:0] rd_data
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [3:0] cnt_r;
  logic rw_r;
  cvtreg_pkg::cvtreg_sp_e st_r;

  wire scl_s = scl_sync_r[1];
  wire sda_s = sda_sync_r[1];
  wire start_c = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  wire stop_c = scl_s & scl_prev_r & ~sda_prev_r & sda_s;
  wire rise_c = scl_s & ~scl_prev_r;
  wire fall_c = ~scl_s & scl_prev_r;
  wire byte_done = (cnt_r == 4'h8);
  wire receiving = (st_r == cvtreg_pkg::SP_ADDR) ||
    (st_r == cvtreg_pkg::SP_PTR) || (st_r == cvtreg_pkg::SP_WDATA);

  // Pins are asynchronous to CLOCK
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_pin};
      sda_sync_r <= {sda_sync_r[0], sda_pin};
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= cvtreg_pkg::SP_IDLE;
      sda_oe_n <= 1'b1;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      reg_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (sreset || stop_c)
      begin
        st_r <= cvtreg_pkg::SP_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (start_c)
      begin
        st_r <= cvtreg_pkg::SP_ADDR;
        cnt_r <= 4'h0;
        sda_oe_n <= 1'b1;
      end
      else if (rise_c)
      begin
        if (receiving || st_r == cvtreg_pkg::SP_RDATA)
        begin
          shift_r <= {shift_r[6:0], sda_s};
          cnt_r <= cnt_r + 4'h1;
        end
        else if (st_r == cvtreg_pkg::SP_RDATA_ACK && sda_s)
        begin
          st_r <= cvtreg_pkg::SP_IDLE;
        end
      end
      else if (fall_c)
      begin
        case (st_r)
          cvtreg_pkg::SP_ADDR:
            if (byte_done)
            begin
              if (shift_r[7:1] == cvtreg_pkg::DEV_ADDR)
              begin
                st_r <= cvtreg_pkg::SP_ADDR_ACK;
                rw_r <= shift_r[0];
                sda_oe_n <= 1'b0;
              end
              else
              begin
                st_r <= cvtreg_pkg::SP_IDLE;
              end
            end
          cvtreg_pkg::SP_PTR:
            if (byte_done)
            begin
              reg_addr <= shift_r;
              st_r <= cvtreg_pkg::SP_PTR_ACK;
              sda_oe_n <= 1'b0;
            end
          cvtreg_pkg::SP_WDATA:
            if (byte_done)
            begin
              wr_data <= shift_r;
              wr_stb <= 1'b1;
              st_r <= cvtreg_pkg::SP_WDATA_ACK;
              sda_oe_n <= 1'b0;
            end
          cvtreg_pkg::SP_ADDR_ACK,
          cvtreg_pkg::SP_RDATA_ACK:
          begin
            cnt_r <= 4'h0;
            if (rw_r)
            begin
              st_r <= cvtreg_pkg::SP_RDATA;
              sda_oe_n <= rd_data[7];
              tx_r <= {rd_data[6:0], 1'b0};
            end
            else
            begin
              st_r <= cvtreg_pkg::SP_PTR;
              sda_oe_n <= 1'b1;
            end
          end
          cvtreg_pkg::SP_PTR_ACK,
          cvtreg_pkg::SP_WDATA_ACK:
          begin
            cnt_r <= 4'h0;
            st_r <= cvtreg_pkg::SP_WDATA;
            sda_oe_n <= 1'b1;
            if (st_r == cvtreg_pkg::SP_WDATA_ACK)
            begin
              reg_addr <= reg_addr + 8'h01;
            end
          end
          cvtreg_pkg::SP_RDATA:
            if (byte_done)
            begin
              st_r <= cvtreg_pkg::SP_RDATA_ACK;
              sda_oe_n <= 1'b1;
              reg_addr <= reg_addr + 8'h01;
            end
            else
            begin
              sda_oe_n <= tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          default:
            sda_oe_n <= 1'b1;
        endcase
      end
    end
  end
endmodule : cvtreg_serial
`default_nettype wire

//--- cvtreg_top.sv
// Control and status register slice with enable sequencing
`default_nettype none
module cvtreg_top #(
  parameter int unsigned MS_CYCLES = cvtreg_pkg::MS_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic ENABLE_INPUT_PIN,
  input wire logic ANALOG_SUPPLY_LOW,
  input wire logic DIE_ABOVE_SHUTDOWN,
  input wire logic DIE_ABOVE_125C,
  input wire logic DIE_ABOVE_105C,
  input wire logic LOAD_RESULT_READY,
  input wire logic [3:0] CONV_CURRENT_LIMIT,
  input wire logic CONV0_POWER_GOOD,
  input wire logic CONV0_SHORT_CIRCUIT,
  output logic CONVERTER_ENABLE,
  output logic ENABLE_ONE_PULLDOWN_ON,
  output logic ENABLE_TWO_PULLDOWN_ON,
  output logic SPREAD_SPECTRUM_ON,
  output logic OTP_RELOAD,
  output logic INT_OUT,
  output logic INT_OE_N
);
  localparam int NSYNC = 12;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic [7:0] delays_r;
  logic [7:0] config_r;
  logic [3:0] top_flags_r;
  logic [7:0] conv01_r;
  logic [7:0] conv23_r;
  logic otp_r;
  logic int_r;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic [NSYNC-1:0] prev_r;
  cvtreg_pkg::cvtreg_seq_e seq_r;
  logic [17:0] ms_cnt_r;
  logic [3:0] step_r;
  logic [7:0] reg_addr;
  logic [7:0] wr_data;
  logic wr_stb;
  logic [7:0] rd_data;

  // Two-stage synchronisers for every asynchronous analog or pin input
  wire [NSYNC-1:0] raw_in = {CONV0_SHORT_CIRCUIT, CONV0_POWER_GOOD,
    CONV_CURRENT_LIMIT, LOAD_RESULT_READY, DIE_ABOVE_105C, DIE_ABOVE_125C,
    DIE_ABOVE_SHUTDOWN, ANALOG_SUPPLY_LOW, ENABLE_INPUT_PIN};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge CLOCK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= raw_in[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  wire [NSYNC-1:0] rise = sync_r & ~prev_r;
  wire en_s = sync_r[0];
  wire uv_s = sync_r[1];
  wire tsd_live = sync_r[2];
  wire warn_live = config_r[cvtreg_pkg::WARN_SEL_BIT] ?
    sync_r[4] : sync_r[3];
  wire load_evt = rise[5];
  wire [3:0] ilim_evt = rise[9:6];
  wire pg_evt = rise[10];
  wire sc_evt = rise[11];

  // Register writes
  wire wr_delays = wr_stb && hit(reg_addr, cvtreg_pkg::OFF_ENABLE_EDGE_DELAYS);
  wire wr_cfg = wr_stb && hit(reg_addr, cvtreg_pkg::OFF_GENERAL_CONFIGURATION);
  wire wr_top = wr_stb && hit(reg_addr, cvtreg_pkg::OFF_TOP_INTERRUPT_FLAGS);
  wire wr_c01 = wr_stb && hit(reg_addr, cvtreg_pkg::OFF_CONVERTER_0_1_FLAGS);
  wire wr_c23 = wr_stb && hit(reg_addr, cvtreg_pkg::OFF_CONVERTER_2_3_FLAGS);
  wire soft_req = wr_stb &&
    hit(reg_addr, cvtreg_pkg::OFF_SOFTWARE_RESET_REQUEST) &&
    wr_data[cvtreg_pkg::SOFT_RESET_BIT];
  // Undervoltage holds the slice in restart for as long as it lasts
  wire restart = soft_req || uv_s;

  wire [3:0] on_delay_field =
    delays_r[cvtreg_pkg::ON_DELAY_MSB:cvtreg_pkg::ON_DELAY_LSB];
  wire [3:0] off_delay_field =
    delays_r[cvtreg_pkg::OFF_DELAY_MSB:cvtreg_pkg::OFF_DELAY_LSB];
  wire tsd_flag = top_flags_r[cvtreg_pkg::TSD_BIT];

  // Per-converter pending summaries
  wire [3:0] pending = {conv23_r[4], conv01_r[4], conv23_r[0],
    |(conv01_r & 8'h07)};
  wire [3:0] summary = {pending[3], pending[1], pending[2], pending[0]};

  // Latched flags: a set in the same cycle as a write-one clear wins
  wire [3:0] top_set;
  assign top_set[cvtreg_pkg::TSD_BIT] = tsd_live;
  assign top_set[cvtreg_pkg::TWARN_BIT] = warn_live;
  assign top_set[cvtreg_pkg::RESET_EVT_BIT] = restart;
  assign top_set[cvtreg_pkg::LOAD_RDY_BIT] = load_evt;
  wire [3:0] top_clr = wr_top ? wr_data[3:0] : 4'h0;
  wire [3:0] top_flags_nxt = restart ? top_set :
    ((top_flags_r & ~top_clr) | top_set);
  wire [7:0] c01_set = {3'h0, ilim_evt[1], 1'b0, pg_evt, sc_evt, ilim_evt[0]};
  wire [7:0] c23_set = {3'h0, ilim_evt[3], 3'h0, ilim_evt[2]};
  wire [7:0] c01_nxt = restart ? c01_set : ((conv01_r &
    ~(wr_c01 ? wr_data : 8'h00)) | c01_set) & cvtreg_pkg::CONV01_MASK;
  wire [7:0] c23_nxt = restart ? c23_set : ((conv23_r &
    ~(wr_c23 ? wr_data : 8'h00)) | c23_set) & cvtreg_pkg::CONV23_MASK;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      delays_r <= cvtreg_pkg::RST_DELAYS;
      config_r <= cvtreg_pkg::RST_CONFIG;
      top_flags_r <= cvtreg_pkg::RST_TOP_FLAGS;
      conv01_r <= 8'h00;
      conv23_r <= 8'h00;
      otp_r <= 1'b0;
      int_r <= 1'b0;
    end
    else
    begin
      otp_r <= restart;
      top_flags_r <= top_flags_nxt;
      conv01_r <= c01_nxt;
      conv23_r <= c23_nxt;
      int_r <= (|top_flags_nxt) || (|c01_nxt) || (|c23_nxt);
      if (restart)
      begin
        delays_r <= cvtreg_pkg::RST_DELAYS;
        config_r <= cvtreg_pkg::RST_CONFIG;
      end
      else
      begin
        if (wr_delays)
        begin
          delays_r <= wr_data;
        end
        if (wr_cfg)
        begin
          config_r <= {4'h0, wr_data[3:0]};
        end
      end
    end
  end

  // Enable sequencer with a millisecond step timer restarted on each edge,
  // so a delay of N steps lasts N ms exactly rather than N-1 to N ms
  wire ms_tick = (ms_cnt_r == 18'(MS_CYCLES - 1));
  wire on_done = (step_r == on_delay_field);
  wire off_done = (step_r == off_delay_field);
  wire seq_start = (seq_r == cvtreg_pkg::SEQ_OFF) && en_s && !tsd_flag;
  wire seq_stop = (seq_r == cvtreg_pkg::SEQ_ON) && !en_s;
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      seq_r <= cvtreg_pkg::SEQ_OFF;
      ms_cnt_r <= 18'h00000;
      step_r <= 4'h0;
    end
    else if (restart || tsd_live || tsd_flag)
    begin
      seq_r <= cvtreg_pkg::SEQ_OFF;
      ms_cnt_r <= 18'h00000;
      step_r <= 4'h0;
    end
    else
    begin
      ms_cnt_r <= (ms_tick || seq_start || seq_stop) ? 18'h00000 :
        ms_cnt_r + 18'h00001;
      if (ms_tick)
      begin
        step_r <= step_r + 4'h1;
      end
      case (seq_r)
        cvtreg_pkg::SEQ_OFF:
          if (seq_start)
          begin
            step_r <= 4'h0;
            seq_r <= cvtreg_pkg::SEQ_START_WAIT;
          end
        cvtreg_pkg::SEQ_START_WAIT:
          if (!en_s)
          begin
            seq_r <= cvtreg_pkg::SEQ_OFF;
          end
          else if (on_done)
          begin
            seq_r <= cvtreg_pkg::SEQ_ON;
          end
        cvtreg_pkg::SEQ_ON:
          if (seq_stop)
          begin
            step_r <= 4'h0;
            seq_r <= cvtreg_pkg::SEQ_STOP_WAIT;
          end
        cvtreg_pkg::SEQ_STOP_WAIT:
          if (en_s)
          begin
            seq_r <= cvtreg_pkg::SEQ_ON;
          end
          else if (off_done)
          begin
            seq_r <= cvtreg_pkg::SEQ_OFF;
          end
        default:
          seq_r <= cvtreg_pkg::SEQ_OFF;
      endcase
    end
  end

  // Read mux; the soft reset register always reads zero
  wire [7:0] top_rd = {summary, top_flags_r};
  wire [7:0] live_rd = {4'h0, tsd_live, warn_live, 2'h0};
  assign rd_data =
    hit(reg_addr, cvtreg_pkg::OFF_ENABLE_EDGE_DELAYS) ? delays_r :
    hit(reg_addr, cvtreg_pkg::OFF_GENERAL_CONFIGURATION) ? config_r :
    hit(reg_addr, cvtreg_pkg::OFF_TOP_INTERRUPT_FLAGS) ? top_rd :
    hit(reg_addr, cvtreg_pkg::OFF_CONVERTER_0_1_FLAGS) ? conv01_r :
    hit(reg_addr, cvtreg_pkg::OFF_CONVERTER_2_3_FLAGS) ? conv23_r :
    hit(reg_addr, cvtreg_pkg::OFF_LIVE_STATUS) ? live_rd :
    8'h00;

  cvtreg_serial u_serial (
    .clk(CLOCK),
    .rst_n(RST_N),
    .sreset(soft_req),
    .scl_pin(SCL),
    .sda_pin(SDA_IN),
    .sda_oe_n(SDA_OE_N),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_data(rd_data)
  );

  assign SDA_OUT = 1'b0;
  assign INT_OUT = 1'b0;
  assign INT_OE_N = ~int_r;
  assign OTP_RELOAD = otp_r;
  assign CONVERTER_ENABLE = (seq_r == cvtreg_pkg::SEQ_ON) ||
    (seq_r == cvtreg_pkg::SEQ_STOP_WAIT);
  assign ENABLE_ONE_PULLDOWN_ON = config_r[cvtreg_pkg::PD_ONE_BIT];
  assign ENABLE_TWO_PULLDOWN_ON = config_r[cvtreg_pkg::PD_TWO_BIT];
  assign SPREAD_SPECTRUM_ON = config_r[cvtreg_pkg::SPREAD_BIT];
endmodule : cvtreg_top
`default_nettype wire

//--- cvtreg_top_chk.sv
// Port assertions for the converter register slice
`default_nettype none
module cvtreg_top_chk #(
  parameter int unsigned MS_CYCLES = 20
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic ENABLE_INPUT_PIN,
  input wire logic ANALOG_SUPPLY_LOW,
  input wire logic DIE_ABOVE_SHUTDOWN,
  input wire logic DIE_ABOVE_125C,
  input wire logic DIE_ABOVE_105C,
  input wire logic LOAD_RESULT_READY,
  input wire logic [3:0] CONV_CURRENT_LIMIT,
  input wire logic CONV0_POWER_GOOD,
  input wire logic CONV0_SHORT_CIRCUIT,
  input wire logic CONVERTER_ENABLE,
  input wire logic ENABLE_ONE_PULLDOWN_ON,
  input wire logic ENABLE_TWO_PULLDOWN_ON,
  input wire logic SPREAD_SPECTRUM_ON,
  input wire logic OTP_RELOAD,
  input wire logic INT_OUT,
  input wire logic INT_OE_N
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  chk_pins_low: assert property (!SDA_OUT && !INT_OUT)
    else $error("open drain value not low");
  chk_load_int: assert property (
    $rose(LOAD_RESULT_READY) |-> ##[1:8] !INT_OE_N)
    else $error("load event gave no interrupt");
  chk_ilim_int: assert property (
    $rose(CONV_CURRENT_LIMIT[3]) |-> ##[1:8] !INT_OE_N)
    else $error("limit event gave no interrupt");
  chk_hot_stop: assert property (
    DIE_ABOVE_SHUTDOWN |-> ##[1:6] !CONVERTER_ENABLE)
    else $error("converter kept on when hot");
  chk_hot_hold: assert property (
    DIE_ABOVE_SHUTDOWN [*6] |-> !CONVERTER_ENABLE)
    else $error("converter on during shutdown");
  chk_uv_defaults: assert property (
    ANALOG_SUPPLY_LOW [*6] |-> !CONVERTER_ENABLE && !INT_OE_N &&
    ENABLE_ONE_PULLDOWN_ON && ENABLE_TWO_PULLDOWN_ON && !SPREAD_SPECTRUM_ON)
    else $error("undervoltage state wrong");
  chk_start_cause: assert property (
    $rose(CONVERTER_ENABLE) |-> $past(ENABLE_INPUT_PIN, 2))
    else $error("converter started without enable");
  chk_reset_vals: assert property (
    $rose(RST_N) |-> ENABLE_ONE_PULLDOWN_ON && ENABLE_TWO_PULLDOWN_ON &&
    !SPREAD_SPECTRUM_ON ##1 !INT_OE_N)
    else $error("reset values wrong");
  cov_start: cover property ($rose(CONVERTER_ENABLE));
  cov_hot: cover property (DIE_ABOVE_SHUTDOWN && CONVERTER_ENABLE);
  cov_otp: cover property (OTP_RELOAD);
endmodule : cvtreg_top_chk
bind cvtreg_top cvtreg_top_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .ENABLE_INPUT_PIN(ENABLE_INPUT_PIN),
  .ANALOG_SUPPLY_LOW(ANALOG_SUPPLY_LOW),
  .DIE_ABOVE_SHUTDOWN(DIE_ABOVE_SHUTDOWN),
  .DIE_ABOVE_125C(DIE_ABOVE_125C), .DIE_ABOVE_105C(DIE_ABOVE_105C),
  .LOAD_RESULT_READY(LOAD_RESULT_READY),
  .CONV_CURRENT_LIMIT(CONV_CURRENT_LIMIT),
  .CONV0_POWER_GOOD(CONV0_POWER_GOOD),
  .CONV0_SHORT_CIRCUIT(CONV0_SHORT_CIRCUIT),
  .CONVERTER_ENABLE(CONVERTER_ENABLE),
  .ENABLE_ONE_PULLDOWN_ON(ENABLE_ONE_PULLDOWN_ON),
  .ENABLE_TWO_PULLDOWN_ON(ENABLE_TWO_PULLDOWN_ON),
  .SPREAD_SPECTRUM_ON(SPREAD_SPECTRUM_ON), .OTP_RELOAD(OTP_RELOAD),
  .INT_OUT(INT_OUT), .INT_OE_N(INT_OE_N));
`default_nettype wire

//--- cvtreg_top_tb.sv
// Self-checking bench for the converter control register slice
`default_nettype none
module cvtreg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
  end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic uv = 1'b0;
  logic tsd = 1'b0;
  logic w125 = 1'b0;
  logic w105 = 1'b0;
  logic [6:0] ev = 7'h00;
  wire scl, hl, sda, sd_o, sd_oe_n, cv, pd1, pd2, ss, otp, io, io_n;
  int fail_count = 0;
  int check_count = 0;
  int otp_count = 0;
  int n;
  assign sda = !(hl || !sd_oe_n);
  always #2.5 clk = ~clk;
  always @(posedge clk)
    if (otp === 1'b1)
      otp_count++;
  cvtreg_top #(.MS_CYCLES(MS)) dut (.CLOCK(clk), .RST_N(rst_n),
    .SCL(scl), .SDA_IN(sda), .SDA_OUT(sd_o), .SDA_OE_N(sd_oe_n),
    .ENABLE_INPUT_PIN(en), .ANALOG_SUPPLY_LOW(uv),
    .DIE_ABOVE_SHUTDOWN(tsd), .DIE_ABOVE_125C(w125),
    .DIE_ABOVE_105C(w105), .LOAD_RESULT_READY(ev[0]),
    .CONV_CURRENT_LIMIT(ev[4:1]), .CONV0_POWER_GOOD(ev[5]),
    .CONV0_SHORT_CIRCUIT(ev[6]), .CONVERTER_ENABLE(cv),
    .ENABLE_ONE_PULLDOWN_ON(pd1), .ENABLE_TWO_PULLDOWN_ON(pd2),
    .SPREAD_SPECTRUM_ON(ss), .OTP_RELOAD(otp), .INT_OUT(io),
    .INT_OE_N(io_n));
  cvtreg_host host (.clk(clk), .scl(scl), .sda_low(hl), .sda(sda));
  task automatic t(input int k);
    repeat (k) @(posedge clk);
  endtask : t
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(a, d, ok);
    `CHK(ok, 1'b1)
  endtask : wr
  task automatic rr(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic ok;
    host.rd(a, v, ok);
    `CHK(ok, 1'b1)
    `CHK(v, e)
  endtask : rr
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    t(6);
    ev[b] <= 1'b0;
    t(6);
  endtask : pulse
  // Bounded so a stuck sequencer ends the wait instead of the run
  task automatic wc(input logic lvl);
    n = 0;
    while (cv !== lvl && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wc
  task automatic test_reset;
    rr(8'h12, 8'h00);
    rr(8'h16, 8'h00);
    wr(8'h30, 8'hFF);
    rr(8'h17, 8'h06);
    rr(8'h30, 8'h00);
    rr(8'h18, 8'h02);
    `CHK({pd2, pd1, ss, io_n}, 4'hC)
    $display("reset test done");
  endtask : test_reset
  task automatic test_config;
    wr(8'h17, 8'h09);
    rr(8'h17, 8'h09);
    `CHK({pd2, pd1, ss}, 3'h1)
    wr(8'h17, 8'h04);
    `CHK({pd2, pd1, ss}, 3'h4)
    wr(8'h18, 8'h06);
    rr(8'h18, 8'h00);
    `CHK(io_n, 1'b1)
    w105 <= 1'b1;
    t(10);
    rr(8'h18, 8'h00);
    w125 <= 1'b1;
    t(10);
    w125 <= 1'b0;
    w105 <= 1'b0;
    rr(8'h18, 8'h04);
    wr(8'h18, 8'h04);
    wr(8'h17, 8'h08);
    w105 <= 1'b1;
    t(10);
    rr(8'h1B, 8'h04);
    w105 <= 1'b0;
    rr(8'h18, 8'h04);
    wr(8'h18, 8'h04);
    $display("config test done");
  endtask : test_config
  task automatic test_flags;
    logic [7:0] a, m;
    pulse(0);
    rr(8'h18, 8'h01);
    `CHK(io_n, 1'b0)
    wr(8'h18, 8'hFE);
    rr(8'h18, 8'h01);
    wr(8'h18, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      a = (i < 2) ? 8'h19 : 8'h1A;
      m = (i % 2 == 1) ? 8'h10 : 8'h01;
      pulse(1 + i);
      rr(8'h18, 8'h10 << i);
      rr(a, m);
      wr(a, m);
      rr(8'h18, 8'h00);
    end
    pulse(5);
    pulse(6);
    rr(8'h19, 8'h06);
    wr(8'h19, 8'h02);
    rr(8'h18, 8'h10);
    wr(8'h19, 8'h04);
    rr(8'h18, 8'h00);
    $display("flag test done");
  endtask : test_flags
  task automatic test_delays;
    wr(8'h12, 8'h32);
    en <= 1'b1;
    wc(1'b1);
    `CHK(n >= 2 * MS && n <= 2 * MS + 6, 1'b1)
    en <= 1'b0;
    wc(1'b0);
    `CHK(n >= 3 * MS && n <= 3 * MS + 6, 1'b1)
    en <= 1'b1;
    t(MS);
    en <= 1'b0;
    t(3 * MS);
    `CHK(cv, 1'b0)
    wr(8'h12, 8'hF0);
    en <= 1'b1;
    wc(1'b1);
    `CHK(n <= 6, 1'b1)
    en <= 1'b0;
    wc(1'b0);
    `CHK(n >= 15 * MS && n <= 15 * MS + 6, 1'b1)
    $display("delay test done");
  endtask : test_delays
  task automatic test_thermal;
    wr(8'h12, 8'h01);
    en <= 1'b1;
    wc(1'b1);
    tsd <= 1'b1;
    t(8);
    `CHK(cv, 1'b0)
    rr(8'h1B, 8'h08);
    tsd <= 1'b0;
    t(3 * MS);
    `CHK(cv, 1'b0)
    rr(8'h1B, 8'h00);
    rr(8'h18, 8'h08);
    wr(8'h18, 8'h08);
    wc(1'b1);
    `CHK(n <= MS + 8, 1'b1)
    en <= 1'b0;
    wc(1'b0);
    $display("thermal test done");
  endtask : test_thermal
  task automatic test_resets;
    int c;
    logic ok;
    wr(8'h17, 8'h01);
    wr(8'h12, 8'h55);
    c = otp_count;
    // The port resets itself in the data byte's ack slot, so the last ack is not judged
    host.wr(8'h16, 8'h01, ok);
    t(20);
    `CHK(otp_count > c, 1'b1)
    rr(8'h16, 8'h00);
    rr(8'h17, 8'h06);
    rr(8'h12, 8'h00);
    rr(8'h18, 8'h02);
    wr(8'h18, 8'h02);
    wr(8'h17, 8'h09);
    uv <= 1'b1;
    t(10);
    uv <= 1'b0;
    t(10);
    rr(8'h17, 8'h06);
    rr(8'h18, 8'h02);
    $display("reset event test done");
  endtask : test_resets
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial
  begin
    t(4);
    rst_n <= 1'b1;
    t(4);
    test_reset;
    test_config;
    test_flags;
    test_delays;
    test_thermal;
    test_resets;
    end_of_test;
  end
  initial
  begin
    #450000;
    fail_count++;
    end_of_test;
  end
endmodule : cvtreg_top_tb
`default_nettype wire
